// ===== logic/index_stack_unit.sv
// Index extension decoder and system stack pointer unit with an APB register port.
// Assumes the register file answers index and address register reads combinationally.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module index_stack_unit #(
  parameter int APB_AW = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output var ixsp_pkg::index_sel_type o_index_sel,
  input wire logic [31:0] i_index_value,
  input wire ixsp_pkg::stack_req_type i_stack_req,
  output logic o_stack_ready,
  input wire logic [31:0] i_areg_value,
  output var ixsp_pkg::mem_access_type o_access,
  output var ixsp_pkg::areg_update_type o_areg_wr,
  output logic [31:0] o_index,
  output logic [31:0] o_ea,
  output logic o_supervisor
);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Software visible state.
  logic [15:0] ext_word;
  logic [15:0] status_word;
  logic [31:0] priv_sp;
  logic [31:0] unpriv_sp;
  logic [31:0] base_addr;
  logic base_supp;
  // Stack sequencer state.
  ixsp_pkg::state_type state;
  ixsp_pkg::state_type next_state;
  // Combinational results of the index decoder.
  logic [31:0] index_now;
  logic [31:0] disp_now;
  logic [31:0] ea_now;
  // Values chosen for the next memory access and register write-back.
  ixsp_pkg::mem_access_type next_access;
  ixsp_pkg::areg_update_type next_areg;
  // Hardware update of one of the two stack pointers.
  logic sp_we;
  logic sp_priv;
  logic [31:0] sp_val;
  logic set_super;
  // Helpers for the stack path.
  logic sup_mode;
  logic [31:0] active_sp;
  logic [31:0] step;
  logic [31:0] cur;
  logic [31:0] moved;
  logic is_sys;
  logic acc_req;
  logic wr_en;
  logic [31:0] rd_now;

  // True when the address names an implemented register.
  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    reg_hit = (o == ixsp_pkg::OFS_EXT_WORD) || (o == ixsp_pkg::OFS_STATUS_WORD) ||
              (o == ixsp_pkg::OFS_PRIV_SP) || (o == ixsp_pkg::OFS_UNPRIV_SP) ||
              (o == ixsp_pkg::OFS_BASE_ADDR) || (o == ixsp_pkg::OFS_FULL_CTRL) ||
              (o == ixsp_pkg::OFS_INDEX_RESULT) || (o == ixsp_pkg::OFS_EA_RESULT) ||
              (o == ixsp_pkg::OFS_ACTIVE_SP);
  endfunction : reg_hit

  // Pointer step for a size; bytes on the system stack move a whole word.
  function automatic logic [31:0] step_of(input ixsp_pkg::size_type sz, input logic sys);
    unique case (sz)
      ixsp_pkg::SZ_BYTE: step_of = sys ? ixsp_pkg::STEP_WORD : ixsp_pkg::STEP_BYTE;
      ixsp_pkg::SZ_WORD: step_of = ixsp_pkg::STEP_WORD;
      default: step_of = ixsp_pkg::STEP_LONG;
    endcase
  endfunction : step_of

  // Builds one memory access record.
  function automatic ixsp_pkg::mem_access_type make_acc(input logic wr, input logic [31:0] a,
      input ixsp_pkg::size_type sz, input ixsp_pkg::src_type s, input logic hi, input logic [31:0] d);
    make_acc.valid = 1'b1;
    make_acc.write = wr;
    make_acc.src = s;
    make_acc.size = sz;
    make_acc.upper_byte = hi;
    make_acc.addr = a;
    make_acc.data = d;
  endfunction : make_acc

  // Index extraction is shared with the register file port.
  index_scale u_scale (
    .i_ext_word(ext_word),
    .i_value(i_index_value),
    .o_sel(o_index_sel),
    .o_index(index_now),
    .o_disp(disp_now)
  );

  // The base register is left out of the sum when suppressed.
  assign ea_now = (base_supp ? 32'h00000000 : base_addr) + index_now + disp_now;

  // Results are registered every cycle, whatever the scale, so latency is fixed.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_index <= 32'h00000000;
      o_ea <= 32'h00000000;
    end else begin
      o_index <= index_now;
      o_ea <= ea_now;
    end
  end

  // APB: zero wait states; read data is captured in the setup cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !reg_hit(i_paddr);
  assign wr_en = i_psel && i_penable && i_pwrite && reg_hit(i_paddr);

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    unique case (8'(i_paddr))
      ixsp_pkg::OFS_EXT_WORD: rd_now = {16'h0000, ext_word};
      ixsp_pkg::OFS_STATUS_WORD: rd_now = {16'h0000, status_word};
      ixsp_pkg::OFS_PRIV_SP: rd_now = priv_sp;
      ixsp_pkg::OFS_UNPRIV_SP: rd_now = unpriv_sp;
      ixsp_pkg::OFS_BASE_ADDR: rd_now = base_addr;
      ixsp_pkg::OFS_FULL_CTRL: rd_now = {31'h00000000, base_supp};
      ixsp_pkg::OFS_INDEX_RESULT: rd_now = o_index;
      ixsp_pkg::OFS_EA_RESULT: rd_now = o_ea;
      ixsp_pkg::OFS_ACTIVE_SP: rd_now = active_sp;
      default: rd_now = 32'h00000000;
    endcase
  end

  // Read data flop, loaded at the end of the setup cycle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= rd_now;
    end
  end

  // Plain configuration registers written by software.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_word <= ixsp_pkg::EXT_RESET;
      base_addr <= ixsp_pkg::BASE_RESET;
      base_supp <= ixsp_pkg::FULL_SUPP_RESET;
    end else if (wr_en) begin
      if (8'(i_paddr) == ixsp_pkg::OFS_EXT_WORD) begin
        ext_word <= i_pwdata[15:0];
      end
      if (8'(i_paddr) == ixsp_pkg::OFS_BASE_ADDR) begin
        base_addr <= i_pwdata;
      end
      if (8'(i_paddr) == ixsp_pkg::OFS_FULL_CTRL) begin
        base_supp <= i_pwdata[ixsp_pkg::FULL_SUPP_BIT];
      end
    end
  end

  // Status word; a trap entering supervisor state wins over a software write.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_word <= ixsp_pkg::SW_RESET;
    end else if (set_super) begin
      status_word[ixsp_pkg::SW_SUPER_BIT] <= 1'b1;
    end else if (wr_en && 8'(i_paddr) == ixsp_pkg::OFS_STATUS_WORD) begin
      status_word <= i_pwdata[15:0];
    end
  end

  assign sup_mode = status_word[ixsp_pkg::SW_SUPER_BIT];
  assign o_supervisor = sup_mode;
  // The active pointer follows the supervisor bit; the other one is hidden.
  assign active_sp = sup_mode ? priv_sp : unpriv_sp;

  // Stack pointers; hardware pointer motion wins over a software write.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      priv_sp <= ixsp_pkg::SP_RESET;
      unpriv_sp <= ixsp_pkg::SP_RESET;
    end else begin
      if (sp_we && sp_priv) begin
        priv_sp <= sp_val;
      end else if (wr_en && 8'(i_paddr) == ixsp_pkg::OFS_PRIV_SP) begin
        priv_sp <= i_pwdata;
      end
      if (sp_we && !sp_priv) begin
        unpriv_sp <= sp_val;
      end else if (wr_en && 8'(i_paddr) == ixsp_pkg::OFS_UNPRIV_SP) begin
        unpriv_sp <= i_pwdata;
      end
    end
  end

  // A request is taken only while the sequencer is idle.
  assign o_stack_ready = (state == ixsp_pkg::ST_IDLE);
  assign acc_req = i_stack_req.valid && o_stack_ready;
  assign is_sys = (i_stack_req.num == ixsp_pkg::STACK_NUM);
  assign step = step_of(i_stack_req.size, is_sys);
  assign cur = is_sys ? active_sp : i_areg_value;

  // Chooses the next access, pointer update and state.
  always_comb begin
    next_state = state;
    next_access = '0;
    next_areg = '0;
    sp_we = 1'b0;
    sp_priv = sup_mode;
    sp_val = active_sp;
    set_super = 1'b0;
    moved = cur;
    unique case (state)
      ixsp_pkg::ST_IDLE: begin
        if (i_stack_req.valid) begin
          unique case (i_stack_req.op)
            ixsp_pkg::OP_PREDEC, ixsp_pkg::OP_POSTINC: begin
              // Predecrement moves first; postincrement uses the old value.
              if (i_stack_req.op == ixsp_pkg::OP_PREDEC) begin
                moved = cur - step;
                next_access = make_acc(i_stack_req.write, moved, i_stack_req.size,
                                       ixsp_pkg::SRC_DATA, is_sys && i_stack_req.size == ixsp_pkg::SZ_BYTE, 32'h0);
              end else begin
                moved = cur + step;
                next_access = make_acc(i_stack_req.write, cur, i_stack_req.size,
                                       ixsp_pkg::SRC_DATA, is_sys && i_stack_req.size == ixsp_pkg::SZ_BYTE, 32'h0);
              end
              if (is_sys) begin
                sp_we = 1'b1;
                sp_val = moved;
              end else begin
                next_areg.valid = 1'b1;
                next_areg.num = i_stack_req.num;
                next_areg.value = moved;
              end
            end
            ixsp_pkg::OP_CALL: begin
              // The return address goes onto the active stack.
              next_access = make_acc(1'b1, active_sp - ixsp_pkg::STEP_LONG, ixsp_pkg::SZ_LONG,
                                     ixsp_pkg::SRC_PC, 1'b0, i_stack_req.pc);
              sp_we = 1'b1;
              sp_val = active_sp - ixsp_pkg::STEP_LONG;
            end
            ixsp_pkg::OP_RET: begin
              // The return address is pulled from the same active stack.
              next_access = make_acc(1'b0, active_sp, ixsp_pkg::SZ_LONG, ixsp_pkg::SRC_PC, 1'b0, 32'h0);
              sp_we = 1'b1;
              sp_val = active_sp + ixsp_pkg::STEP_LONG;
            end
            ixsp_pkg::OP_TRAP: begin
              // Trap frame always lands on the privileged stack, PC first.
              next_access = make_acc(1'b1, priv_sp - ixsp_pkg::STEP_LONG, ixsp_pkg::SZ_LONG,
                                     ixsp_pkg::SRC_PC, 1'b0, i_stack_req.pc);
              sp_we = 1'b1;
              sp_priv = 1'b1;
              sp_val = priv_sp - ixsp_pkg::STEP_LONG;
              next_state = ixsp_pkg::ST_TRAP_SW;
            end
            default: begin
              // Undefined operation codes are dropped.
              next_state = ixsp_pkg::ST_IDLE;
            end
          endcase
        end
      end
      ixsp_pkg::ST_TRAP_SW: begin
        // Status word saved as it stood before the switch to supervisor.
        next_access = make_acc(1'b1, priv_sp - ixsp_pkg::STEP_WORD, ixsp_pkg::SZ_WORD,
                               ixsp_pkg::SRC_SW, 1'b0, {16'h0000, status_word});
        sp_we = 1'b1;
        sp_priv = 1'b1;
        sp_val = priv_sp - ixsp_pkg::STEP_WORD;
        set_super = 1'b1;
        next_state = ixsp_pkg::ST_IDLE;
      end
      default: begin
        next_state = ixsp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ixsp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Access and write-back outputs are registered one cycle after acceptance.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_access <= '0;
      o_areg_wr <= '0;
    end else begin
      o_access <= next_access;
      o_areg_wr <= next_areg;
    end
  end

  // Checks on the index path.
  chk_type_select: assert property (o_index_sel.is_addr == ext_word[ixsp_pkg::EXT_TYPE_BIT])
    else $error("index register type does not follow the type bit");
  chk_word_sext: assert property ((!ext_word[11] && ext_word[10:9] == 2'h0 && !wr_en) |=>
    (o_index == {{16{$past(i_index_value[15])}}, $past(i_index_value[15:0])}))
    else $error("word index not sign extended");
  chk_long_plain: assert property ((ext_word[11] && ext_word[10:9] == 2'h0) |=>
    (o_index == $past(i_index_value)))
    else $error("unscaled long index altered");
  chk_scale_eight: assert property ((ext_word[11] && ext_word[10:9] == 2'h3) |=>
    (o_index == {$past(i_index_value[28:0]), 3'h0}))
    else $error("scale code 11 did not multiply by eight");
  chk_base_suppress: assert property (base_supp |=> (o_ea == o_index + $past(disp_now)))
    else $error("base register used while suppressed");

  // Checks on the stack path.
  chk_super_map: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_PREDEC && is_sys && sup_mode &&
    i_stack_req.size == ixsp_pkg::SZ_LONG && !wr_en) |=>
    (priv_sp == $past(priv_sp) - 32'h4) && (unpriv_sp == $past(unpriv_sp)))
    else $error("supervisor push moved the wrong pointer");
  chk_predec_addr: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_PREDEC && !is_sys &&
    i_stack_req.size == ixsp_pkg::SZ_LONG) |=>
    (o_access.valid && o_access.addr == $past(i_areg_value) - 32'h4 && o_areg_wr.value == o_access.addr))
    else $error("predecrement address wrong");
  chk_postinc_addr: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_POSTINC && !is_sys &&
    i_stack_req.size == ixsp_pkg::SZ_WORD) |=>
    (o_access.addr == $past(i_areg_value) && o_areg_wr.value == $past(i_areg_value) + 32'h2))
    else $error("postincrement address wrong");
  chk_call_push: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_CALL) |=>
    (o_access.write && o_access.src == ixsp_pkg::SRC_PC && o_access.addr == $past(active_sp) - 32'h4))
    else $error("call did not push PC on active stack");
  chk_trap_frame: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_TRAP) |=>
    (o_access.src == ixsp_pkg::SRC_PC && o_access.addr == $past(priv_sp) - 32'h4) ##1
    (o_access.src == ixsp_pkg::SRC_SW && o_access.size == ixsp_pkg::SZ_WORD && sup_mode))
    else $error("trap frame not on privileged stack");
  chk_byte_sp: assert property ((acc_req && i_stack_req.op == ixsp_pkg::OP_PREDEC && is_sys &&
    i_stack_req.size == ixsp_pkg::SZ_BYTE) |=>
    (o_access.upper_byte && o_access.addr == $past(active_sp) - 32'h2))
    else $error("byte push broke word alignment");

  cov_trap: cover property (acc_req && i_stack_req.op == ixsp_pkg::OP_TRAP && !sup_mode);
  cov_byte_push: cover property (acc_req && is_sys && i_stack_req.size == ixsp_pkg::SZ_BYTE);
  cov_scaled_word: cover property (!ext_word[11] && ext_word[10:9] == 2'h3 && i_index_value[15]);
  cov_user_pull: cover property (acc_req && i_stack_req.op == ixsp_pkg::OP_POSTINC && !is_sys);

endmodule : index_stack_unit

`default_nettype wire

// ===== logic/ixsp_pkg.sv
// Shared constants and types for the index decode and stack pointer unit.
// Assumes one processor clock; the register file and sequencer sit outside.
`default_nettype none

package ixsp_pkg;

  // Field positions inside the brief extension word.
  localparam int EXT_TYPE_BIT = 15;
  localparam int EXT_NUM_LSB = 12;
  localparam int EXT_WIDTH_BIT = 11;
  localparam int EXT_SCALE_LSB = 9;
  localparam int EXT_DISP_LSB = 0;

  // Supervisor state bit inside the status word.
  localparam int SW_SUPER_BIT = 13;
  // Base register suppress bit inside the full-format control register.
  localparam int FULL_SUPP_BIT = 0;

  // Address register number that names the system stack pointer.
  localparam logic [2:0] STACK_NUM = 3'h7;

  // APB byte offsets of the registers.
  localparam logic [7:0] OFS_EXT_WORD = 8'h00;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
  localparam logic [7:0] OFS_PRIV_SP = 8'h08;
  localparam logic [7:0] OFS_UNPRIV_SP = 8'h0c;
  localparam logic [7:0] OFS_BASE_ADDR = 8'h10;
  localparam logic [7:0] OFS_FULL_CTRL = 8'h14;
  localparam logic [7:0] OFS_INDEX_RESULT = 8'h18;
  localparam logic [7:0] OFS_EA_RESULT = 8'h1c;
  localparam logic [7:0] OFS_ACTIVE_SP = 8'h20;

  // Reset values.
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam logic [15:0] SW_RESET = 16'h2000;
  localparam logic [31:0] SP_RESET = 32'h00000000;
  localparam logic [31:0] BASE_RESET = 32'h00000000;
  localparam logic FULL_SUPP_RESET = 1'b0;

  // Pointer steps in bytes.
  localparam logic [31:0] STEP_BYTE = 32'h00000001;
  localparam logic [31:0] STEP_WORD = 32'h00000002;
  localparam logic [31:0] STEP_LONG = 32'h00000004;

  // Operand sizes.
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_type;

  // Stack and pointer operations requested by the sequencer.
  typedef enum logic [2:0] {
    OP_PREDEC = 3'h0, OP_POSTINC = 3'h1, OP_CALL = 3'h2, OP_RET = 3'h3, OP_TRAP = 3'h4
  } op_type;

  // What a memory access carries.
  typedef enum logic [1:0] {SRC_DATA = 2'h0, SRC_PC = 2'h1, SRC_SW = 2'h2} src_type;

  // Stack sequencer states, one-hot.
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_TRAP_SW = 2'b10} state_type;

  // Index register selection sent to the register file.
  typedef struct packed {
    logic is_addr;
    logic [2:0] num;
  } index_sel_type;

  // Request from the sequencer.
  typedef struct packed {
    logic valid;
    op_type op;
    size_type size;
    logic write;
    logic [2:0] num;
    logic [31:0] pc;
  } stack_req_type;

  // Memory access issued toward the bus interface.
  typedef struct packed {
    logic valid;
    logic write;
    src_type src;
    size_type size;
    logic upper_byte;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_access_type;

  // Write-back of a general address register.
  typedef struct packed {
    logic valid;
    logic [2:0] num;
    logic [31:0] value;
  } areg_update_type;

endpackage : ixsp_pkg

`default_nettype wire

// ===== logic/index_scale.sv
// Brief extension word decoder: index selection, sizing, scaling, displacement.
// Assumes the register file returns the selected register within the same cycle.
`timescale 1ns/1ns
`default_nettype none

module index_scale (
  input wire logic [15:0] i_ext_word,
  input wire logic [31:0] i_value,
  output var ixsp_pkg::index_sel_type o_sel,
  output logic [31:0] o_index,
  output logic [31:0] o_disp
);

  // Index value after width selection, before scaling.
  logic [31:0] sized;

  // Purely combinational, so scaling costs no extra cycle.
  always_comb begin
    o_sel.is_addr = i_ext_word[ixsp_pkg::EXT_TYPE_BIT];
    o_sel.num = i_ext_word[ixsp_pkg::EXT_NUM_LSB +: 3];
    // A word index is sign extended from its low half.
    if (i_ext_word[ixsp_pkg::EXT_WIDTH_BIT]) begin
      sized = i_value;
    end else begin
      sized = {{16{i_value[15]}}, i_value[15:0]};
    end
    // Scale 00 leaves the index untouched, as the older format did.
    o_index = sized << i_ext_word[ixsp_pkg::EXT_SCALE_LSB +: 2];
    o_disp = {{24{i_ext_word[ixsp_pkg::EXT_DISP_LSB + 7]}}, i_ext_word[ixsp_pkg::EXT_DISP_LSB +: 8]};
  end

endmodule : index_scale

`default_nettype wire

// ===== sim/regfile_model.sv
// Register file model facing the index and stack unit.
// Assumes reads answer in the same cycle and write-backs land at the clock edge.
`timescale 1ns/1ns
`default_nettype none
module regfile_model (
  input wire logic i_clk,
  input wire ixsp_pkg::index_sel_type i_sel,
  input wire logic [2:0] i_num,
  input wire ixsp_pkg::areg_update_type i_wr,
  output logic [31:0] o_index_value,
  output logic [31:0] o_areg_value
);
  logic [31:0] dreg [8]; // Data registers, low words negative to show sign extension.
  logic [31:0] areg [8]; // Address registers.
  // Known start values so the bench can predict every read.
  initial begin
    for (int i = 0; i < 8; i++) begin
      dreg[i] = 32'h12348000 | i;
      areg[i] = 32'h00010000 + 32'(i) * 32'h00000100;
    end
  end
  // Same-cycle reads of the selected registers.
  assign o_index_value = i_sel.is_addr ? areg[i_sel.num] : dreg[i_sel.num];
  // Write-through: a write-back still pending is seen by a read of the same register.
  assign o_areg_value = (i_wr.valid && i_wr.num == i_num) ? i_wr.value : areg[i_num];
  // Write-back of a general address register at the edge.
  always @(posedge i_clk) begin
    if (i_wr.valid) areg[i_wr.num] <= i_wr.value;
  end
endmodule : regfile_model
`default_nettype wire

// ===== sim/tb_index_extension_and_stack_pointer.sv
// Self-checking bench for the index decode and stack pointer unit.
// Assumes the register file model answers reads in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module tb_index_extension_and_stack_pointer;
  logic i_clk, i_nrst, psel, penable, pwrite, pready, pslverr, rdy, sup, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, idxv, aregv, oidx, oea, rnd, rd, psp, upsp, e, b, v, x;
  ixsp_pkg::index_sel_type sel;
  ixsp_pkg::stack_req_type req;
  ixsp_pkg::mem_access_type acc;
  ixsp_pkg::areg_update_type awr;
  ixsp_pkg::mem_access_type acc_q[$]; // Expected accesses, oldest first.
  ixsp_pkg::areg_update_type wr_q[$]; // Expected register write-backs.
  int err_total = 0;
  int samples_checked = 0;
  index_stack_unit i_index_stack_unit (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_index_sel(sel), .i_index_value(idxv), .i_stack_req(req), .o_stack_ready(rdy),
    .i_areg_value(aregv), .o_access(acc), .o_areg_wr(awr), .o_index(oidx), .o_ea(oea), .o_supervisor(sup));
  regfile_model i_regfile_model (.i_clk(i_clk), .i_sel(sel), .i_num(req.num), .i_wr(awr),
    .o_index_value(idxv), .o_areg_value(aregv));
  // Free-running clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Pseudo-random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected index value from the model's start contents.
  function automatic logic [31:0] idx_exp(input logic [15:0] w);
    logic [31:0] r;
    r = w[15] ? 32'h00010000 + {21'h0, w[14:12], 8'h0} : 32'h12348000 | {29'h0, w[14:12]};
    if (!w[11]) r = {{16{r[15]}}, r[15:0]};
    return r << w[10:9];
  endfunction : idx_exp
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [70:0] ev, input logic [70:0] got);
    samples_checked++;
    if (got !== ev) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, ev, got);
    end
  endtask : check
  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    // The request stands until pready is seen high at a rising edge.
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reads a register and compares data and error flag.
  task automatic rdchk(input string what, input logic [7:0] ad, input logic [31:0] ev, input logic ee);
    apb(1'b0, ad, 32'h0);
    check(what, {38'h0, ee, ev}, {38'h0, er, rd});
  endtask : rdchk
  // Holds a stack request until the unit takes it.
  task automatic stk(input ixsp_pkg::op_type op, input ixsp_pkg::size_type sz, input logic w,
                     input logic [2:0] n, input logic [31:0] pc);
    @(posedge i_clk);
    req <= '{1'b1, op, sz, w, n, pc};
    do begin
      @(posedge i_clk);
    end while (rdy !== 1'b1);
    req.valid <= 1'b0;
  endtask : stk
  // Notes one expected memory access.
  task automatic ex(input logic w, input ixsp_pkg::src_type s, input ixsp_pkg::size_type sz, input logic ub,
                    input logic [31:0] ad, input logic [31:0] d);
    acc_q.push_back('{1'b1, w, s, sz, ub, ad, d});
  endtask : ex
  // Watches results and compares each with the oldest note.
  always @(posedge i_clk) begin
    ixsp_pkg::mem_access_type m;
    ixsp_pkg::areg_update_type u;
    if (i_nrst && acc.valid === 1'b1) begin
      m = (acc_q.size() > 0) ? acc_q.pop_front() : '0;
      // Data of reads and plain data moves is not predicted here.
      if (!(m.write && m.src != ixsp_pkg::SRC_DATA)) m.data = acc.data;
      check("access", m, acc);
    end
    if (i_nrst && awr.valid === 1'b1) begin
      u = (wr_q.size() > 0) ? wr_q.pop_front() : '0;
      check("areg write", {35'h0, u}, {35'h0, awr});
    end
  end
  // Main sequence: reset values, index decode, stack traffic.
  initial begin
    i_nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req = '0;
    rnd = 32'h7c80;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdchk("status reset", ixsp_pkg::OFS_STATUS_WORD, 32'h00002000, 1'b0);
    rdchk("unmapped", 8'h24, 32'h0, 1'b1);
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      e = {16'h0, rnd[15:11], k[1:0], rnd[8:0]};
      b = lfsr(rnd ^ 32'h5a5a0000);
      apb(1'b1, ixsp_pkg::OFS_EXT_WORD, e);
      apb(1'b1, ixsp_pkg::OFS_BASE_ADDR, b);
      apb(1'b1, ixsp_pkg::OFS_FULL_CTRL, {31'h0, k[2]});
      repeat (2) @(negedge i_clk);
      v = idx_exp(e[15:0]);
      x = (k[2] ? 32'h0 : b) + v + {{24{e[7]}}, e[7:0]};
      check("index select", {67'h0, e[15:12]}, {67'h0, sel});
      check("index value", {39'h0, v}, {39'h0, oidx});
      check("effective address", {39'h0, x}, {39'h0, oea});
    end
    psp = 32'h00001000;
    upsp = 32'h00002000;
    apb(1'b1, ixsp_pkg::OFS_PRIV_SP, psp);
    apb(1'b1, ixsp_pkg::OFS_UNPRIV_SP, upsp);
    ex(1'b1, ixsp_pkg::SRC_PC, ixsp_pkg::SZ_LONG, 1'b0, psp - 4, 32'habcd0100);
    stk(ixsp_pkg::OP_CALL, ixsp_pkg::SZ_LONG, 1'b1, 3'h7, 32'habcd0100);
    ex(1'b0, ixsp_pkg::SRC_PC, ixsp_pkg::SZ_LONG, 1'b0, psp - 4, 32'h0);
    stk(ixsp_pkg::OP_RET, ixsp_pkg::SZ_LONG, 1'b0, 3'h7, 32'h0);
    ex(1'b1, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_BYTE, 1'b1, psp - 2, 32'h0);
    stk(ixsp_pkg::OP_PREDEC, ixsp_pkg::SZ_BYTE, 1'b1, 3'h7, 32'h0);
    ex(1'b0, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_BYTE, 1'b1, psp - 2, 32'h0);
    stk(ixsp_pkg::OP_POSTINC, ixsp_pkg::SZ_BYTE, 1'b0, 3'h7, 32'h0);
    // A long push and pull in supervisor state move only the privileged pointer.
    ex(1'b1, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_LONG, 1'b0, psp - 4, 32'h0);
    stk(ixsp_pkg::OP_PREDEC, ixsp_pkg::SZ_LONG, 1'b1, 3'h7, 32'h0);
    ex(1'b0, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_LONG, 1'b0, psp - 4, 32'h0);
    stk(ixsp_pkg::OP_POSTINC, ixsp_pkg::SZ_LONG, 1'b0, 3'h7, 32'h0);
    ex(1'b1, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_LONG, 1'b0, 32'h000102fc, 32'h0);
    wr_q.push_back('{1'b1, 3'h3, 32'h000102fc});
    stk(ixsp_pkg::OP_PREDEC, ixsp_pkg::SZ_LONG, 1'b1, 3'h3, 32'h0);
    ex(1'b0, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_WORD, 1'b0, 32'h000102fc, 32'h0);
    wr_q.push_back('{1'b1, 3'h3, 32'h000102fe});
    stk(ixsp_pkg::OP_POSTINC, ixsp_pkg::SZ_WORD, 1'b0, 3'h3, 32'h0);
    ex(1'b0, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_BYTE, 1'b0, 32'h00010600, 32'h0);
    wr_q.push_back('{1'b1, 3'h6, 32'h00010601});
    stk(ixsp_pkg::OP_POSTINC, ixsp_pkg::SZ_BYTE, 1'b0, 3'h6, 32'h0);
    apb(1'b1, ixsp_pkg::OFS_STATUS_WORD, 32'h0);
    @(negedge i_clk);
    check("supervisor", 71'h0, {70'h0, sup});
    ex(1'b1, ixsp_pkg::SRC_DATA, ixsp_pkg::SZ_LONG, 1'b0, upsp - 4, 32'h0);
    stk(ixsp_pkg::OP_PREDEC, ixsp_pkg::SZ_LONG, 1'b1, 3'h7, 32'h0);
    rdchk("active sp", ixsp_pkg::OFS_ACTIVE_SP, upsp - 4, 1'b0);
    ex(1'b1, ixsp_pkg::SRC_PC, ixsp_pkg::SZ_LONG, 1'b0, psp - 4, 32'h00005678);
    ex(1'b1, ixsp_pkg::SRC_SW, ixsp_pkg::SZ_WORD, 1'b0, psp - 6, 32'h0);
    stk(ixsp_pkg::OP_TRAP, ixsp_pkg::SZ_LONG, 1'b1, 3'h7, 32'h00005678);
    // An undefined operation right behind the trap must be dropped.
    stk(ixsp_pkg::op_type'(3'h5), ixsp_pkg::SZ_LONG, 1'b1, 3'h7, 32'h0);
    repeat (3) @(negedge i_clk);
    rdchk("priv sp after trap", ixsp_pkg::OFS_PRIV_SP, psp - 6, 1'b0);
    rdchk("status after trap", ixsp_pkg::OFS_STATUS_WORD, 32'h00002000, 1'b0);
    check("pending notes", 71'h0, {39'h0, 32'(acc_q.size() + wr_q.size())});
    summarize();
  end
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    summarize();
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
endmodule : tb_index_extension_and_stack_pointer
`default_nettype wire
